// [hw/pio_consts.vh]
`ifndef PIO_CONSTS_VH
`define PIO_CONSTS_VH

// Register bus geometry
`define ADDR_W          4
`define DATA_W          16

// Register offsets on the plain register port
`define OFF_PA_SEL      4'h0
`define OFF_PA_DIR      4'h1
`define OFF_PA_DAT      4'h2
`define OFF_PB_SEL      4'h3
`define OFF_PB_DIR      4'h4
`define OFF_PB_DAT      4'h5
`define OFF_MASK        4'h6
`define OFF_SYSCTL      4'h7

// Reset values
`define RST_PA_SEL      16'h0000
`define RST_PA_DIR      16'h0000
`define RST_PA_DAT      16'h0000
`define RST_PB_SEL      8'h80
`define RST_PB_DIR      12'h000
`define RST_PB_DAT      12'h000
`define RST_MASK        4'h0
`define RST_SYSCTL      1'b0

// Port B pin positions: lower pins in peripheral mode, then refresh and interrupt base at bit 8
`define BIT_ACK7        0
`define BIT_ACK6        1
`define BIT_ACK1        2
`define BIT_TIMER1_INPUT        3
`define BIT_TIMER1_OUTPUT       4
`define BIT_TIMER2_INPUT        5
`define BIT_TIMER2_OUTPUT       6
`define BIT_WATCHDOG_EXPIRY_OUTPUT        7
`define BIT_REFRESH     8
`define BIT_IRQ_LO      8

// Peripheral-mode push-pull outputs on port B bits 0, 1, 2, 4 and 6
`define PB_PERIPH_DRV   8'h57

// Refresh-request select bit in the system control register
`define SYSCTL_REFRESH  0

// Level fed to a timer input while its pin is general purpose
`define TIMER_TIE       1'b0

`endif

// [hw/parallel_io_port_b.v]
// Operation
// - Port B has twelve pins, eight selectable
// - Bits 11..8 always general purpose, interrupting
// - Lower eight follow select, direction, data registers
// - Reset makes bit 7 watchdog open-drain
// - Peripheral order: acks, timers, watchdog
// - Timer input tied low in GP mode
// - Bit 8 doubles as refresh request
// - Direction bit clear input, set output
// - Reset clears upper direction bits
// - Reset clears the interrupt mask register
// - Data writes always load output latch
// - Read latch for outputs, pin for inputs
// - Falling edge on upper input requests interrupt
// - Fixed priority among four requests, level 4
// - Each request masked by its own bit
// - Three 16-bit registers per port
// - Reserved bits read back as zero
// - Select bit set hands pin to peripheral
// - Peripheral mode: own direction, state readback
// - Reset clears port A select and direction
`timescale 1ns/1ps
`include "pio_consts.vh"

module parallel_io_port_b #(
    parameter PA_W      = 16,
    parameter PB_W      = 12,
    parameter PB_SEL_W  = 8,
    parameter IRQ_W     = 4,
    parameter [15:0] PA_GP_TIE = 16'h0000
) (
    input  wire                 CLK,
    input  wire                 RST,
    input  wire [`ADDR_W-1:0]   ADDR,
    input  wire [`DATA_W-1:0]   WR_DATA,
    input  wire                 WR_EN,
    input  wire                 RD_EN,
    output wire [`DATA_W-1:0]   RD_DATA,
    input  wire [PA_W-1:0]      PA_PIN_IN,
    output wire [PA_W-1:0]      PA_PIN_OUT,
    output wire [PA_W-1:0]      PA_PIN_OE,
    input  wire [PA_W-1:0]      PA_PERIPH_OUT,
    input  wire [PA_W-1:0]      PA_PERIPH_OE,
    output wire [PA_W-1:0]      PA_PERIPH_IN,
    input  wire [PB_W-1:0]      PB_PIN_IN,
    output wire [PB_W-1:0]      PB_PIN_OUT,
    output wire [PB_W-1:0]      PB_PIN_OE,
    input  wire                 LEVEL7_ACK,
    input  wire                 LEVEL6_ACK,
    input  wire                 LEVEL1_ACK,
    input  wire                 TIMER1_OUT,
    input  wire                 TIMER2_OUT,
    input  wire                 WATCHDOG_EXPIRY,
    output wire                 TIMER1_IN,
    output wire                 TIMER2_IN,
    output wire                 DRAM_REFRESH_REQ,
    output wire [IRQ_W-1:0]     PIN_IRQ_REQ,
    output wire                 PIN_IRQ_ANY,
    output wire [1:0]           PIN_IRQ_ID
);

    // Push-pull peripheral pins; bit 7 stays with the watchdog,
    // which may only sink, so it never joins this mask
    localparam [7:0] PB_DRV_MASK = `PB_PERIPH_DRV;

    // Address match for one register offset
    function hit;
        input [`ADDR_W-1:0] addr;
        input [`ADDR_W-1:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    // Per-bit readback: peripheral state, latch or live pin
    function rd_bit;
        input sel;
        input dir;
        input latch;
        input pin;
        input pdrv;
        input poe;
        begin
            if (sel) begin
                rd_bit = poe ? pdrv : pin;
            end else begin
                rd_bit = dir ? latch : pin;
            end
        end
    endfunction

    // Software-visible registers
    reg [PA_W-1:0]      pa_sel_ff;
    reg [PA_W-1:0]      pa_dir_ff;
    reg [PA_W-1:0]      pa_dat_ff;
    reg [PB_SEL_W-1:0]  pb_sel_ff;
    reg [PB_W-1:0]      pb_dir_ff;
    reg [PB_W-1:0]      pb_dat_ff;
    reg [IRQ_W-1:0]     mask_ff;
    reg                 refresh_sel_ff;

    // Pin synchronisers and edge history
    reg [PA_W-1:0]      pa_s1_ff;
    reg [PA_W-1:0]      pa_s2_ff;
    reg [PB_W-1:0]      pb_s1_ff;
    reg [PB_W-1:0]      pb_s2_ff;
    reg [IRQ_W-1:0]     prev_ff;

    // Registered outputs
    reg [`DATA_W-1:0]   rd_data_ff;
    reg [PA_W-1:0]      pa_out_ff;
    reg [PA_W-1:0]      pa_oe_ff;
    reg [PA_W-1:0]      pa_pin_to_per_ff;
    reg [PB_W-1:0]      pb_out_ff;
    reg [PB_W-1:0]      pb_oe_ff;
    reg                 timer1_input_ff;
    reg                 timer2_input_ff;
    reg                 refresh_ff;
    reg [IRQ_W-1:0]     irq_ff;
    reg                 irq_any_ff;
    reg [1:0]           irq_id_ff;

    // Combinational next values
    reg [`DATA_W-1:0]   nxt_rd_data;
    reg [PA_W-1:0]      nxt_pa_out;
    reg [PA_W-1:0]      nxt_pa_oe;
    reg [PB_W-1:0]      nxt_pb_out;
    reg [PB_W-1:0]      nxt_pb_oe;
    reg [IRQ_W-1:0]     nxt_irq;
    reg [1:0]           nxt_irq_id;

    wire [PB_W-1:0]     pb_sel_full;
    wire [PB_W-1:0]     pb_pdrv;
    wire [PB_W-1:0]     pb_poe;
    wire [PA_W-1:0]     pa_rd;
    wire [PB_W-1:0]     pb_rd;
    wire [IRQ_W-1:0]    fall;
    wire [`DATA_W-1:0]  pb_sel_word;
    wire [`DATA_W-1:0]  pb_dir_word;
    wire [`DATA_W-1:0]  pb_dat_word;
    wire [`DATA_W-1:0]  mask_word;
    wire [`DATA_W-1:0]  sysctl_word;

    // Upper four pins have no select bit, so they stay GP
    assign pb_sel_full = {4'h0, pb_sel_ff};

    // Peripheral drive values in pin order
    assign pb_pdrv = {4'h0,
                      1'b0,                               // Watchdog pulls low
                      TIMER2_OUT,
                      1'b0,
                      TIMER1_OUT,
                      1'b0,
                      LEVEL1_ACK,
                      LEVEL6_ACK,
                      LEVEL7_ACK};

    // Watchdog only sinks while expired: open drain
    assign pb_poe = {4'h0,
                     WATCHDOG_EXPIRY,
                     PB_DRV_MASK[6:0]};

    // Readback per bit for both ports
    genvar gi;
    generate
        for (gi = 0; gi < PA_W; gi = gi + 1) begin : g_pa_rd
            assign pa_rd[gi] = rd_bit(pa_sel_ff[gi],
                                      pa_dir_ff[gi],
                                      pa_dat_ff[gi],
                                      pa_s2_ff[gi],
                                      PA_PERIPH_OUT[gi],
                                      PA_PERIPH_OE[gi]);
        end
        for (gi = 0; gi < PB_W; gi = gi + 1) begin : g_pb_rd
            assign pb_rd[gi] = rd_bit(pb_sel_full[gi],
                                      pb_dir_ff[gi],
                                      pb_dat_ff[gi],
                                      pb_s2_ff[gi],
                                      pb_pdrv[gi],
                                      pb_poe[gi]);
        end
    endgenerate

    // Falling edge, only on pins set as inputs
    // An output pin follows its own latch, so it must stay quiet
    assign fall = prev_ff & ~pb_s2_ff[PB_W-1:`BIT_IRQ_LO]
                  & ~pb_dir_ff[PB_W-1:`BIT_IRQ_LO];

    // Read words: reserved bits are wired to zero, never stored
    assign pb_sel_word = {{(`DATA_W-PB_SEL_W){1'b0}}, pb_sel_ff};
    assign pb_dir_word = {{(`DATA_W-PB_W){1'b0}}, pb_dir_ff};
    assign pb_dat_word = {{(`DATA_W-PB_W){1'b0}}, pb_rd};
    assign mask_word   = {{(`DATA_W-IRQ_W){1'b0}}, mask_ff};
    assign sysctl_word = {{(`DATA_W-1){1'b0}}, refresh_sel_ff};

    // Register writes; reserved bits are never stored
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            pa_sel_ff      <= `RST_PA_SEL;
            pa_dir_ff      <= `RST_PA_DIR;
            pa_dat_ff      <= `RST_PA_DAT;
            pb_sel_ff      <= `RST_PB_SEL;
            pb_dir_ff      <= `RST_PB_DIR;
            pb_dat_ff      <= `RST_PB_DAT;
            mask_ff        <= `RST_MASK;
            refresh_sel_ff <= `RST_SYSCTL;
        end else if (WR_EN) begin
            if (hit(ADDR, `OFF_PA_SEL)) begin
                pa_sel_ff <= WR_DATA[PA_W-1:0];
            end
            if (hit(ADDR, `OFF_PA_DIR)) begin
                pa_dir_ff <= WR_DATA[PA_W-1:0];
            end
            if (hit(ADDR, `OFF_PA_DAT)) begin
                pa_dat_ff <= WR_DATA[PA_W-1:0];
            end
            if (hit(ADDR, `OFF_PB_SEL)) begin
                pb_sel_ff <= WR_DATA[PB_SEL_W-1:0];
            end
            if (hit(ADDR, `OFF_PB_DIR)) begin
                pb_dir_ff <= WR_DATA[PB_W-1:0];
            end
            if (hit(ADDR, `OFF_PB_DAT)) begin
                pb_dat_ff <= WR_DATA[PB_W-1:0];
            end
            if (hit(ADDR, `OFF_MASK)) begin
                mask_ff <= WR_DATA[IRQ_W-1:0];
            end
            if (hit(ADDR, `OFF_SYSCTL)) begin
                refresh_sel_ff <= WR_DATA[`SYSCTL_REFRESH];
            end
        end
    end

    // Read mux; unmapped offsets and reserved bits give zero
    always @* begin
        nxt_rd_data = 16'h0000;
        if (RD_EN) begin
            case (ADDR)
                `OFF_PA_SEL: begin
                    nxt_rd_data = pa_sel_ff;
                end
                `OFF_PA_DIR: begin
                    nxt_rd_data = pa_dir_ff;
                end
                `OFF_PA_DAT: begin
                    nxt_rd_data = pa_rd;
                end
                `OFF_PB_SEL: begin
                    nxt_rd_data = pb_sel_word;
                end
                `OFF_PB_DIR: begin
                    nxt_rd_data = pb_dir_word;
                end
                `OFF_PB_DAT: begin
                    nxt_rd_data = pb_dat_word;
                end
                `OFF_MASK: begin
                    nxt_rd_data = mask_word;
                end
                `OFF_SYSCTL: begin
                    nxt_rd_data = sysctl_word;
                end
                default: begin
                    nxt_rd_data = 16'h0000;
                end
            endcase
        end
    end

    // Pin drive: peripheral owns direction when selected
    always @* begin
        nxt_pa_out = (pa_sel_ff & PA_PERIPH_OUT)
                     | (~pa_sel_ff & pa_dat_ff);
        nxt_pa_oe  = (pa_sel_ff & PA_PERIPH_OE)
                     | (~pa_sel_ff & pa_dir_ff);
        nxt_pb_out = (pb_sel_full & pb_pdrv)
                     | (~pb_sel_full & pb_dat_ff);
        nxt_pb_oe  = (pb_sel_full & pb_poe)
                     | (~pb_sel_full & pb_dir_ff);
    end

    // Masked requests and fixed priority, bit 11 first
    // A masked edge is dropped, not held pending
    always @* begin
        nxt_irq    = fall & mask_ff;
        nxt_irq_id = 2'h0;
        if (nxt_irq[3]) begin
            nxt_irq_id = 2'h3;
        end else if (nxt_irq[2]) begin
            nxt_irq_id = 2'h2;
        end else if (nxt_irq[1]) begin
            nxt_irq_id = 2'h1;
        end else begin
            nxt_irq_id = 2'h0;
        end
    end

    // Two-stage pin synchronisers; only stage two is read
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            pa_s1_ff <= 16'h0000;
            pa_s2_ff <= 16'h0000;
            pb_s1_ff <= 12'h000;
            pb_s2_ff <= 12'h000;
            prev_ff  <= 4'h0;
        end else begin
            pa_s1_ff <= PA_PIN_IN;
            pa_s2_ff <= pa_s1_ff;
            pb_s1_ff <= PB_PIN_IN;
            pb_s2_ff <= pb_s1_ff;
            // History follows the pin so one edge gives one pulse
            prev_ff  <= pb_s2_ff[PB_W-1:`BIT_IRQ_LO];
        end
    end

    // Output flops: a one-cycle lag buys glitch-free pins
    // Reset levels equal the idle levels, so release is quiet
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            rd_data_ff       <= 16'h0000;
            pa_out_ff        <= 16'h0000;
            pa_oe_ff         <= 16'h0000;
            pa_pin_to_per_ff <= 16'h0000;
            pb_out_ff        <= 12'h000;
            pb_oe_ff         <= 12'h000;
            timer1_input_ff          <= `TIMER_TIE;
            timer2_input_ff          <= `TIMER_TIE;
            refresh_ff       <= 1'b0;
            irq_ff           <= 4'h0;
            irq_any_ff       <= 1'b0;
            irq_id_ff        <= 2'h0;
        end else begin
            rd_data_ff <= nxt_rd_data;
            pa_out_ff  <= nxt_pa_out;
            pa_oe_ff   <= nxt_pa_oe;
            // Deselected peripheral inputs see a fixed level
            pa_pin_to_per_ff <= (pa_sel_ff & pa_s2_ff)
                                | (~pa_sel_ff & PA_GP_TIE);
            pb_out_ff  <= nxt_pb_out;
            pb_oe_ff   <= nxt_pb_oe;
            timer1_input_ff    <= pb_sel_ff[`BIT_TIMER1_INPUT]
                          ? pb_s2_ff[`BIT_TIMER1_INPUT]
                          : `TIMER_TIE;
            timer2_input_ff    <= pb_sel_ff[`BIT_TIMER2_INPUT]
                          ? pb_s2_ff[`BIT_TIMER2_INPUT]
                          : `TIMER_TIE;
            // Refresh use leaves the GP function of bit 8 intact
            refresh_ff <= refresh_sel_ff
                          & pb_s2_ff[`BIT_REFRESH];
            irq_ff     <= nxt_irq;
            irq_any_ff <= |nxt_irq;
            irq_id_ff  <= nxt_irq_id;
        end
    end

    assign RD_DATA          = rd_data_ff;
    assign PA_PIN_OUT       = pa_out_ff;
    assign PA_PIN_OE        = pa_oe_ff;
    assign PA_PERIPH_IN     = pa_pin_to_per_ff;
    assign PB_PIN_OUT       = pb_out_ff;
    assign PB_PIN_OE        = pb_oe_ff;
    assign TIMER1_IN        = timer1_input_ff;
    assign TIMER2_IN        = timer2_input_ff;
    assign DRAM_REFRESH_REQ = refresh_ff;
    assign PIN_IRQ_REQ      = irq_ff;
    assign PIN_IRQ_ANY      = irq_any_ff;
    assign PIN_IRQ_ID       = irq_id_ff;

endmodule // parallel_io_port_b

// [testbench/pio_port_monitor.sv]
`timescale 1ns/1ps
`include "pio_consts.vh"
module pio_port_monitor (
    input wire        CLK,
    input wire        RST,
    input wire [3:0]  ADDR,
    input wire [15:0] WR_DATA,
    input wire        WR_EN,
    input wire        RD_EN,
    input wire [15:0] RD_DATA,
    input wire [11:0] PB_PIN_IN,
    input wire [11:0] PB_PIN_OUT,
    input wire [11:0] PB_PIN_OE,
    input wire        TIMER1_IN,
    input wire        DRAM_REFRESH_REQ,
    input wire [3:0]  PIN_IRQ_REQ,
    input wire        PIN_IRQ_ANY,
    input wire [1:0]  PIN_IRQ_ID
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // Bus answers and reset state
    a_rd_idle_zero: assert property (
        !$past(RD_EN) |-> RD_DATA == 16'h0000) else $error("stray read data");
    a_reset_quiet: assert property (
        disable iff (1'b0) RST ##1 RST |->
        PB_PIN_OE == 12'h000 && PIN_IRQ_REQ == 4'h0)
        else $error("outputs active in reset");
    // Requests: one pulse per edge, fixed priority, caused by a fall
    a_irq_once: assert property (
        (PIN_IRQ_REQ & $past(PIN_IRQ_REQ)) == 4'h0) else $error("long request");
    a_irq_prio: assert property (
        PIN_IRQ_ANY |-> (PIN_IRQ_REQ >> PIN_IRQ_ID) == 4'h1)
        else $error("wrong request priority");
    a_irq_cause: assert property (
        (PIN_IRQ_REQ & $past(PB_PIN_IN[11:8], 3)) == 4'h0 &&
        (PIN_IRQ_REQ & ~$past(PB_PIN_IN[11:8], 4)) == 4'h0)
        else $error("request without falling edge");
    // Upper pins follow direction and latch two edges after a write
    a_dir_upper: assert property (
        (WR_EN && ADDR == `OFF_PB_DIR) ##1 !WR_EN |=>
        PB_PIN_OE[11:8] == $past(WR_DATA[11:8], 2)) else $error("dir lost");
    a_latch_out: assert property (
        (WR_EN && ADDR == `OFF_PB_DAT) ##1 !WR_EN |=>
        ((PB_PIN_OUT[11:8] ^ $past(WR_DATA[11:8], 2)) & PB_PIN_OE[11:8])
        == 4'h0) else $error("latch not on pin");
    // Timer and refresh only ever see a high pin
    a_timer_pin: assert property (
        TIMER1_IN |-> $past(PB_PIN_IN[3], 2) || $past(PB_PIN_IN[3], 3) ||
        $past(PB_PIN_IN[3], 4)) else $error("timer input without pin");
    a_refresh_pin: assert property (
        DRAM_REFRESH_REQ |-> $past(PB_PIN_IN[8], 2) ||
        $past(PB_PIN_IN[8], 3) || $past(PB_PIN_IN[8], 4))
        else $error("refresh without pin");
    c_irq: cover property (PIN_IRQ_ANY);
    c_read: cover property (RD_EN ##1 RD_DATA != 16'h0000);
    c_refresh: cover property (DRAM_REFRESH_REQ);
endmodule // pio_port_monitor

bind parallel_io_port_b pio_port_monitor mon (.CLK, .RST, .ADDR, .WR_DATA,
    .WR_EN, .RD_EN, .RD_DATA, .PB_PIN_IN, .PB_PIN_OUT, .PB_PIN_OE,
    .TIMER1_IN, .DRAM_REFRESH_REQ, .PIN_IRQ_REQ, .PIN_IRQ_ANY, .PIN_IRQ_ID);

// [testbench/pio_pins_model.sv]
`timescale 1ns/1ps
module pio_pins_model #(
    parameter W = 12
) (
    input  wire         clk,
    input  wire [W-1:0] drv_out,
    input  wire [W-1:0] drv_oe,
    input  wire [W-1:0] ext_val,
    input  wire [W-1:0] ext_en,
    output wire [W-1:0] level
);
    reg [W-1:0] flt_ff = '0;
    // No pull-ups: an undriven pin wanders every cycle
    always @(posedge clk) flt_ff <= ~flt_ff;
    // Device drive wins, so open drain shows as a plain low
    assign level = (drv_oe & drv_out) | (~drv_oe & ext_en & ext_val) |
                   (~drv_oe & ~ext_en & flt_ff);
endmodule // pio_pins_model

// [testbench/parallel_io_port_b_bench.sv]
`timescale 1ns/1ps
`include "pio_consts.vh"
module parallel_io_port_b_bench;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg  [3:0]  addr = 4'h0;
    reg  [15:0] wdata = 16'h0000;
    reg         wen = 1'b0;
    reg         ren = 1'b0;
    reg  [11:0] pb_ext = 12'hfa8;
    reg  [5:0]  perif = 6'h00; // watchdog_expiry_output, t2o, t1o, ack1, ack6, ack7
    reg  [11:0] pb_en = 12'hfff;
    reg  [15:0] pa_pout = 16'h0000;
    reg  [15:0] pa_poe = 16'h0000;
    wire [15:0] rdata, pa_in, pa_out, pa_oe, pa_per;
    wire [11:0] pb_in, pb_out, pb_oe;
    wire [3:0]  irq;
    wire [1:0]  irq_id;
    wire        irq_any, t1_in, t2_in, refr;
    integer     err_total = 0;
    integer     checks = 0;

    always #2.5 clk = ~clk;

    parallel_io_port_b dut (.CLK(clk), .RST(rst), .ADDR(addr),
        .WR_DATA(wdata), .WR_EN(wen), .RD_EN(ren), .RD_DATA(rdata),
        .PA_PIN_IN(pa_in), .PA_PIN_OUT(pa_out), .PA_PIN_OE(pa_oe),
        .PA_PERIPH_OUT(pa_pout), .PA_PERIPH_OE(pa_poe), .PA_PERIPH_IN(pa_per),
        .PB_PIN_IN(pb_in), .PB_PIN_OUT(pb_out), .PB_PIN_OE(pb_oe),
        .LEVEL7_ACK(perif[0]), .LEVEL6_ACK(perif[1]), .LEVEL1_ACK(perif[2]),
        .TIMER1_OUT(perif[3]), .TIMER2_OUT(perif[4]),
        .WATCHDOG_EXPIRY(perif[5]), .TIMER1_IN(t1_in), .TIMER2_IN(t2_in),
        .DRAM_REFRESH_REQ(refr), .PIN_IRQ_REQ(irq), .PIN_IRQ_ANY(irq_any),
        .PIN_IRQ_ID(irq_id));
    pio_pins_model #(.W(16)) pa_pins (.clk(clk), .drv_out(pa_out),
        .drv_oe(pa_oe), .ext_val(16'ha5c3), .ext_en(16'hffff), .level(pa_in));
    pio_pins_model #(.W(12)) pb_pins (.clk(clk), .drv_out(pb_out),
        .drv_oe(pb_oe), .ext_val(pb_ext), .ext_en(pb_en), .level(pb_in));

    task summarize;
        $display("Checks %0d, errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task set_pb(input [11:0] v);
        @(posedge clk);
        pb_ext <= v;
    endtask
    task wr(input [3:0] a, input [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wen <= 1'b1;
        @(posedge clk);
        wen <= 1'b0;
    endtask
    task rd(input [3:0] a, input [15:0] e);
        @(posedge clk);
        addr <= a;
        ren <= 1'b1;
        @(posedge clk);
        ren <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // First request seen within a bounded window, zero if none
    task irq_chk(input [5:0] e);
        reg [5:0] got;
        integer   k;
        got = 6'h00;
        for (k = 0; k < 12; k = k + 1) begin
            @(posedge clk);
            #1 if (irq_any === 1'b1 && got == 6'h00) got = {irq_id, irq};
        end
        chk({10'h000, got}, {10'h000, e});
    endtask
    task do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        tick(4);
    endtask

    // Hang guard
    initial begin
        #400000;
        err_total = err_total + 1;
        summarize;
    end

    initial begin
        do_reset;
        chk({4'h0, pb_oe}, 16'h0000);
        chk({14'h0, t1_in, t2_in}, 16'h0000);
        rd(`OFF_PA_SEL, 16'h0000);
        rd(`OFF_PA_DIR, 16'h0000);
        rd(`OFF_PA_DAT, 16'ha5c3);
        rd(`OFF_PB_SEL, 16'h0080);
        rd(`OFF_PB_DIR, 16'h0000);
        rd(`OFF_PB_DAT, 16'h0fa8);
        rd(`OFF_MASK, 16'h0000);
        rd(4'h8, 16'h0000);
        // Peripheral mode ignores direction bits
        @(posedge clk);
        perif <= 6'h2d;
        wr(`OFF_PB_DIR, 16'h00ff);
        wr(`OFF_PB_SEL, 16'hffff);
        tick(4);
        chk({4'h0, pb_oe}, 16'h00d7);
        chk({8'h00, pb_out[7:0] & 8'h57}, 16'h0015);
        chk({14'h0, t1_in, t2_in}, 16'h0003);
        rd(`OFF_PB_SEL, 16'h00ff);
        rd(`OFF_PB_DAT, 16'h0f3d);
        // General purpose: latch loads while pins are inputs
        wr(`OFF_PB_SEL, 16'h0000);
        wr(`OFF_PB_DIR, 16'h0000);
        wr(`OFF_PB_DAT, 16'hf05a);
        tick(4);
        chk({14'h0, t1_in, t2_in}, 16'h0000);
        rd(`OFF_PB_DAT, 16'h0fa8);
        wr(`OFF_PB_DIR, 16'hffff);
        tick(4);
        rd(`OFF_PB_DIR, 16'h0fff);
        chk({4'h0, pb_out}, 16'h005a);
        rd(`OFF_PB_DAT, 16'h005a);
        // Falls driven by the device itself raise nothing
        wr(`OFF_MASK, 16'h000f);
        wr(`OFF_PB_DAT, 16'h0f00);
        tick(8);
        wr(`OFF_PB_DAT, 16'h0000);
        irq_chk(6'h00);
        wr(`OFF_PB_DIR, 16'h0000);
        tick(8);
        set_pb(12'h7a8);
        irq_chk(6'h38);
        set_pb(12'hfa8);
        tick(8);
        set_pb(12'h9a8);
        irq_chk(6'h26);
        set_pb(12'hfa8);
        wr(`OFF_MASK, 16'h000d);
        tick(8);
        set_pb(12'hda8);
        irq_chk(6'h00);
        // Refresh request follows bit 8 once selected
        set_pb(12'hfa8);
        wr(`OFF_SYSCTL, 16'h0001);
        tick(6);
        chk({15'h0, refr}, 16'h0001);
        set_pb(12'hea8);
        tick(6);
        chk({15'h0, refr}, 16'h0000);
        // Port A keeps the same three-register scheme
        wr(`OFF_PA_DIR, 16'hffff);
        wr(`OFF_PA_DAT, 16'h1234);
        tick(2);
        chk(pa_oe, 16'hffff);
        chk(pa_out, 16'h1234);
        rd(`OFF_PA_DAT, 16'h1234);
        // Upper port A pins handed to a peripheral
        @(posedge clk);
        pa_pout <= 16'h5a00;
        pa_poe <= 16'h0f00;
        wr(`OFF_PA_SEL, 16'hff00);
        tick(4);
        chk(pa_oe, 16'h0fff);
        chk(pa_out, 16'h5a34);
        chk(pa_per, 16'haa00);
        rd(`OFF_PA_DAT, 16'haa34);
        // Second reset in mid-run
        do_reset;
        rd(`OFF_PB_SEL, 16'h0080);
        rd(`OFF_PB_DIR, 16'h0000);
        rd(`OFF_MASK, 16'h0000);
        rd(`OFF_PA_SEL, 16'h0000);
        rd(`OFF_PA_DIR, 16'h0000);
        // Floating upper pins stay quiet until unmasked
        @(posedge clk);
        pb_en <= 12'h0ff;
        irq_chk(6'h00);
        wr(`OFF_MASK, 16'h000f);
        irq_chk(6'h3f);
        summarize;
    end
endmodule // parallel_io_port_b_bench
